// ### rtl/ppc_top.sv
// Notes on behaviour
// - byte output latch per port
// - direction register, one bit per pin
// - function select: standard io or peripheral
// - read-only pin state register per port
// - direction clear: push-pull drive of latch
// - direction set: no longer push-pull driven
// - function clear: latch and direction control pin
// - function set: peripheral signal drives pin
// - port zero input only, digital and analog
// - mux bus: ports three, four carry bus
// - demux bus: port three is io, port four is io on its low nibble only
// - 4-bit extended port gives upper address
// - ports 1,2,5,6 share same register set
module ppc_top
  import ppc_pkg::*;
#(
  parameter bit MUX_BUS = 1'b1
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // special-function register window
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [PPC_ADDR_W-1:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // external bus
  input wire logic bus_active,
  input wire logic [15:0] bus_ad_out,
  input wire logic bus_ad_oe,
  input wire logic [PPC_EXT_ADDR_W-1:0] bus_ext_addr,
  output logic [15:0] bus_ad_in,
  // peripheral signals
  input wire logic [7:0] periph_out [8],
  input wire logic [7:0] periph_oe [8],
  output logic [7:0] periph_in [8],
  // pins
  input wire logic [7:0] pin_in [8],
  output logic [7:0] pin_out [8],
  output logic [7:0] pin_oe [8],
  output logic [7:0] analog_in_q
);
  // ---------------------------------------------------------------------------
  // register bank
  // ---------------------------------------------------------------------------
  ppc_regs_if regs ();
  logic [2:0] a_port;
  logic [1:0] a_sel;
  assign a_port = sfr_addr[4:2];
  assign a_sel = sfr_addr[1:0];

  ppc_reg_bank u_bank (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(sfr_wr),
    .wr_port(a_port),
    .wr_sel(a_sel),
    .wr_data(sfr_wdata),
    .regs(regs.bank)
  );

  // ---------------------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------------------
  logic [7:0] sync1_q [8];
  logic [7:0] pin_state_q [8];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int p = 0; p < PPC_NUM_PORTS; p++) begin
        sync1_q[p] <= PPC_RD_ZERO;
        pin_state_q[p] <= PPC_RD_ZERO;
      end
    end else begin
      for (int p = 0; p < PPC_NUM_PORTS; p++) begin
        sync1_q[p] <= pin_in[p];
        pin_state_q[p] <= sync1_q[p];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------------------
  logic [7:0] drv_d [8];
  logic [7:0] oe_d [8];
  logic [7:0] mask [8];
  for (genvar p = 0; p < PPC_NUM_PORTS; p++) begin : g_drv
    for (genvar b = 0; b < 8; b++) begin : g_bit
      logic src;
      logic pp;
      always_comb begin
        // function select picks the data source
        src = regs.func_q[p][b] ? periph_out[p][b] : regs.latch_q[p][b];
        // peripheral may release its pin
        pp = !regs.dir_q[p][b] && (!regs.func_q[p][b] || periph_oe[p][b]);
        drv_d[p][b] = src;
        if (pp) begin
          oe_d[p][b] = 1'b1;
        end else begin
          oe_d[p][b] = !src;
        end
      end
    end
    // port width masks
    if (p == PPC_PORT_INPUT_ONLY) begin : g_in
      assign mask[p] = PPC_RD_ZERO;
    end else if (p == PPC_PORT_EXT || (p == PPC_PORT_BUS_HI && !MUX_BUS)) begin : g_nib
      assign mask[p] = PPC_NIBBLE_MASK;
    end else begin : g_full
      assign mask[p] = 8'hff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int p = 0; p < PPC_NUM_PORTS; p++) begin
        pin_out[p] <= PPC_RD_ZERO;
        pin_oe[p] <= PPC_RD_ZERO;
      end
    end else begin
      for (int p = 0; p < PPC_NUM_PORTS; p++) begin
        pin_out[p] <= drv_d[p] & mask[p];
        pin_oe[p] <= oe_d[p] & mask[p];
      end
      if (MUX_BUS && bus_active) begin
        // bus owns ports three and four
        pin_out[PPC_PORT_BUS_LO] <= bus_ad_out[7:0];
        pin_out[PPC_PORT_BUS_HI] <= bus_ad_out[15:8];
        pin_oe[PPC_PORT_BUS_LO] <= {8{bus_ad_oe}};
        pin_oe[PPC_PORT_BUS_HI] <= {8{bus_ad_oe}};
      end
      if (bus_active) begin
        pin_out[PPC_PORT_EXT] <= {4'h0, bus_ext_addr};
        pin_oe[PPC_PORT_EXT] <= PPC_NIBBLE_MASK;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // inputs to bus, peripherals and analog block
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_ad_in <= 16'h0000;
      analog_in_q <= PPC_RD_ZERO;
      for (int p = 0; p < PPC_NUM_PORTS; p++) begin
        periph_in[p] <= PPC_RD_ZERO;
      end
    end else begin
      bus_ad_in <= {pin_state_q[PPC_PORT_BUS_HI], pin_state_q[PPC_PORT_BUS_LO]};
      analog_in_q <= pin_state_q[PPC_PORT_INPUT_ONLY];
      for (int p = 0; p < PPC_NUM_PORTS; p++) begin
        periph_in[p] <= pin_state_q[p];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // register readback, one cycle after sfr_rd
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfr_rdata <= PPC_RD_ZERO;
    end else if (sfr_rd) begin
      unique case (a_sel)
        PPC_REG_LATCH: sfr_rdata <= regs.latch_q[a_port] & mask[a_port];
        PPC_REG_DIR: sfr_rdata <= regs.dir_q[a_port] & mask[a_port];
        PPC_REG_FUNC: sfr_rdata <= regs.func_q[a_port] & mask[a_port];
        PPC_REG_PIN: sfr_rdata <= pin_state_q[a_port] & ((a_port == 3'(PPC_PORT_INPUT_ONLY))
            ? 8'hff : mask[a_port]);
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  // arrays and masks assume eight byte-wide ports and a nibble of upper address
  if (PPC_NUM_PORTS != 8 || PPC_EXT_ADDR_W > 8) begin : g_bad_cfg
    $error("port layout does not fit eight byte-wide ports");
  end

  sequence s_port1_latch_wr;
    sfr_wr && a_port == 3'd1 && a_sel == PPC_REG_LATCH;
  endsequence
  sequence s_port1_bit0_pushpull;
    !regs.dir_q[1][0] && !regs.func_q[1][0];
  endsequence

  AST_IN_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    pin_oe[PPC_PORT_INPUT_ONLY] == 8'h00) else $error("input-only port drives");
  AST_PUSHPULL: assert property (@(posedge clk) disable iff (!rst_n)
    s_port1_bit0_pushpull |=>
      pin_oe[1][0] && pin_out[1][0] == $past(regs.latch_q[1][0]))
    else $error("push-pull output wrong");
  AST_WR_TO_PIN: assert property (@(posedge clk) disable iff (!rst_n)
    s_port1_latch_wr ##1 s_port1_bit0_pushpull |=> pin_out[1][0] == $past(sfr_wdata[0], 2))
    else $error("latch write not seen on pin");
  AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!rst_n)
    (regs.dir_q[1][0] && !regs.func_q[1][0] && regs.latch_q[1][0]) |=> !pin_oe[1][0])
    else $error("input pin driven");
  AST_OD_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    (regs.dir_q[2][1] && !regs.func_q[2][1] && !regs.latch_q[2][1]) |=>
      pin_oe[2][1] && !pin_out[2][1])
    else $error("open-drain low missing");
  AST_PERIPH: assert property (@(posedge clk) disable iff (!rst_n)
    (regs.func_q[2][0] && !regs.dir_q[2][0] && periph_oe[2][0]) |=>
      pin_out[2][0] == $past(periph_out[2][0]))
    else $error("peripheral not routed");
  AST_PIN_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_rd && a_sel == PPC_REG_PIN && a_port == 3'd1) |=> sfr_rdata == $past(pin_state_q[1]))
    else $error("pin readback wrong");
  AST_LATCH_WR: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_wr && a_sel == PPC_REG_LATCH && a_port == 3'd6) |=> regs.latch_q[6] == $past(sfr_wdata))
    else $error("latch write lost");
  AST_BUS_LO: assert property (@(posedge clk) disable iff (!rst_n)
    (MUX_BUS && bus_active) |=> pin_out[PPC_PORT_BUS_LO] == $past(bus_ad_out[7:0]))
    else $error("bus byte not on port three");
  AST_EXT_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
    bus_active |=> pin_out[PPC_PORT_EXT][PPC_EXT_ADDR_W-1:0] == $past(bus_ext_addr)
      && pin_oe[PPC_PORT_EXT] == PPC_NIBBLE_MASK)
    else $error("upper address not on extended port");
  AST_EXT_HI: assert property (@(posedge clk) disable iff (!rst_n)
    pin_oe[PPC_PORT_EXT][7:4] == 4'h0) else $error("extended port upper bits driven");
endmodule

// ### rtl/ppc_pkg.sv
package ppc_pkg;
  // ---------------------------------------------------------------------------
  // register window layout: one byte per register, four per port
  // ---------------------------------------------------------------------------
  localparam int PPC_NUM_PORTS = 8;
  localparam int PPC_ADDR_W = 5;
  localparam logic [1:0] PPC_REG_LATCH = 2'h0;
  localparam logic [1:0] PPC_REG_DIR = 2'h1;
  localparam logic [1:0] PPC_REG_FUNC = 2'h2;
  localparam logic [1:0] PPC_REG_PIN = 2'h3;
  localparam logic [7:0] PPC_LATCH_RST = 8'hff;
  localparam logic [7:0] PPC_DIR_RST = 8'hff;
  localparam logic [7:0] PPC_FUNC_RST = 8'h00;
  localparam logic [7:0] PPC_RD_ZERO = 8'h00;
  // port roles
  localparam int PPC_PORT_INPUT_ONLY = 0;
  localparam int PPC_PORT_BUS_LO = 3;
  localparam int PPC_PORT_BUS_HI = 4;
  localparam int PPC_PORT_EXT = 7;
  localparam logic [7:0] PPC_NIBBLE_MASK = 8'h0f;
  localparam int PPC_EXT_ADDR_W = 4;
endpackage

// ### rtl/ppc_if.sv
// ---------------------------------------------------------------------------
// per-port register set carried from the bank to the pin logic
// ---------------------------------------------------------------------------
interface ppc_regs_if;
  logic [7:0] latch_q [8];
  logic [7:0] dir_q [8];
  logic [7:0] func_q [8];
  modport bank (output latch_q, output dir_q, output func_q);
  modport user (input latch_q, input dir_q, input func_q);
endinterface

// ### rtl/ppc_reg_bank.sv
module ppc_reg_bank
  import ppc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [2:0] wr_port,
  input wire logic [1:0] wr_sel,
  input wire logic [7:0] wr_data,
  // register set out
  ppc_regs_if.bank regs
);
  // ---------------------------------------------------------------------------
  // writable registers, one generate entry per port
  // ---------------------------------------------------------------------------
  for (genvar p = 0; p < PPC_NUM_PORTS; p++) begin : g_port
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        regs.latch_q[p] <= PPC_LATCH_RST;
        regs.dir_q[p] <= PPC_DIR_RST;
        regs.func_q[p] <= PPC_FUNC_RST;
      end else if (wr_en && wr_port == 3'(p)) begin
        if (wr_sel == PPC_REG_LATCH) begin
          regs.latch_q[p] <= wr_data;
        end
        if (wr_sel == PPC_REG_DIR) begin
          regs.dir_q[p] <= wr_data;
        end
        if (wr_sel == PPC_REG_FUNC) begin
          regs.func_q[p] <= wr_data;
        end
      end
    end
  end
endmodule

// ### sim/ppc_pin_model.sv
module ppc_pin_model (
  // design side
  input wire logic [7:0] pin_out [8],
  input wire logic [7:0] pin_oe [8],
  // far-side drive
  input wire logic [7:0] ext_val [8],
  input wire logic [7:0] ext_en [8],
  // resolved pin level
  output logic [7:0] pin_lvl [8]
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up on every pin, so an undriven or open-drain pin floats high
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      pin_lvl[p] = (pin_oe[p] & pin_out[p]) | (~pin_oe[p] & (~ext_en[p] | ext_val[p]));
    end
  end
endmodule

// ### sim/tb.sv
module tb;
  import ppc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, sfr_wr, sfr_rd, bus_active, bus_ad_oe;
  logic [PPC_ADDR_W-1:0] sfr_addr;
  logic [7:0] sfr_wdata, sfr_rdata, analog_in_q, rv;
  logic [15:0] bus_ad_out, bus_ad_in;
  logic [PPC_EXT_ADDR_W-1:0] bus_ext_addr;
  logic [7:0] periph_out [8], periph_oe [8], periph_in [8], pin_lvl [8];
  logic [7:0] pin_out [8], pin_oe [8], ext_val [8], ext_en [8];
  logic [7:0] lat [8], dir [8], fun [8];
  int bad_count, compares, cycles;
  ppc_top i_ppc_top (.clk(clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .bus_active(bus_active), .bus_ad_out(bus_ad_out), .bus_ad_oe(bus_ad_oe),
    .bus_ext_addr(bus_ext_addr), .bus_ad_in(bus_ad_in), .periph_out(periph_out),
    .periph_oe(periph_oe), .periph_in(periph_in), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe(pin_oe), .analog_in_q(analog_in_q));
  ppc_pin_model i_ppc_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_en(ext_en), .pin_lvl(pin_lvl));
  // ---------------------------------------------------------------------------
  // clock, timeout
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  // ---------------------------------------------------------------------------
  // expectation model
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] mk(int p);
    return (p == PPC_PORT_INPUT_ONLY) ? 8'h00 : (p == PPC_PORT_EXT) ? PPC_NIBBLE_MASK : 8'hff;
  endfunction
  function automatic logic [7:0] src(int p);
    return (fun[p] & periph_out[p]) | (~fun[p] & lat[p]);
  endfunction
  function automatic logic [7:0] eoe(int p);
    logic [7:0] drv;
    drv = ~dir[p] & (~fun[p] | periph_oe[p]);
    return (drv | ~src(p)) & mk(p);
  endfunction
  function automatic logic [7:0] elv(int p);
    return (eoe(p) & src(p)) | (~eoe(p) & (~ext_en[p] | ext_val[p]));
  endfunction
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input int p, input logic [1:0] r, input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= 1'b1;
    sfr_addr <= {p[2:0], r};
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
    if (r == PPC_REG_LATCH) lat[p] = d;
    if (r == PPC_REG_DIR) dir[p] = d;
    if (r == PPC_REG_FUNC) fun[p] = d;
  endtask
  task automatic rd(input int p, input logic [1:0] r, output logic [7:0] d);
    @(posedge clk);
    sfr_rd <= 1'b1;
    sfr_addr <= {p[2:0], r};
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask
  task automatic check_all();
    repeat (6) @(posedge clk);
    #1;
    chk8(analog_in_q, elv(0));
    for (int p = 0; p < 8; p++) begin
      chk8(pin_oe[p] & mk(p), eoe(p));
      chk8(pin_out[p] & mk(p), src(p) & mk(p));
      chk8(periph_in[p], elv(p));
      rd(p, PPC_REG_LATCH, rv);
      chk8(rv, lat[p] & mk(p));
      rd(p, PPC_REG_DIR, rv);
      chk8(rv, dir[p] & mk(p));
      rd(p, PPC_REG_FUNC, rv);
      chk8(rv, fun[p] & mk(p));
      rd(p, PPC_REG_PIN, rv);
      chk8(rv, elv(p) & (p == 0 ? 8'hff : mk(p)));
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {rst_n, sfr_wr, sfr_rd, bus_active, bus_ad_oe, sfr_addr, sfr_wdata} = '0;
    {bus_ad_out, bus_ext_addr, bad_count, compares, cycles} = '0;
    for (int p = 0; p < 8; p++) begin
      {periph_out[p], periph_oe[p], ext_val[p], ext_en[p]} = '0;
      lat[p] = PPC_LATCH_RST;
      dir[p] = PPC_DIR_RST;
      fun[p] = PPC_FUNC_RST;
    end
    void'($urandom(32'h9a7c));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    check_all();
    wr(1, PPC_REG_LATCH, 8'h08);
    wr(1, PPC_REG_DIR, 8'hf7);
    wr(2, PPC_REG_DIR, 8'h7e);
    wr(2, PPC_REG_FUNC, 8'h81);
    check_all();
    repeat (6) begin
      for (int p = 0; p < 8; p++) begin
        for (int r = 0; r < 3; r++) wr(p, r[1:0], 8'($urandom));
        periph_out[p] <= 8'($urandom);
        periph_oe[p] <= 8'($urandom);
        ext_val[p] <= 8'($urandom);
        ext_en[p] <= 8'($urandom);
      end
      check_all();
    end
    @(posedge clk);
    {bus_active, bus_ad_oe} <= 2'b11;
    bus_ad_out <= 16'($urandom);
    bus_ext_addr <= 4'($urandom);
    repeat (6) @(posedge clk);
    #1;
    chk8(pin_out[3], bus_ad_out[7:0]);
    chk8(pin_out[4], bus_ad_out[15:8]);
    chk8(pin_oe[4] & pin_oe[3], 8'hff);
    chk8(bus_ad_in[7:0] ^ bus_ad_out[7:0], 8'h00);
    chk8(pin_oe[7] & PPC_NIBBLE_MASK, PPC_NIBBLE_MASK);
    chk8(pin_out[7] & PPC_NIBBLE_MASK, {4'h0, bus_ext_addr});
    @(posedge clk);
    bus_ad_oe <= 1'b0;
    ext_en[3] <= 8'hff;
    ext_en[4] <= 8'hff;
    repeat (6) @(posedge clk);
    #1;
    chk8(pin_oe[3] | pin_oe[4], 8'h00);
    chk8(bus_ad_in[15:8], ext_val[4]);
    chk8(bus_ad_in[7:0], ext_val[3]);
    wrap_up();
  end
endmodule
